// ===== guarded_ops_unit.sv
// What this block does
// - pick byte of first operand by index in second, sign-extend to 32 bits
// - index outside zero to three gives an undefined result
// - with a guard, write destination only when guard bit zero is one
// - clip signed first operand to range minus second minus one up to second
// - cache invalidate clears every block valid bit, locked blocks too
// - cache invalidate leaves replacement state untouched
// - cache invalidate discards all pending instruction prefetches
// - invalidate at i also discards i+1 and i+2, keeps i+3
// - guarded-off invalidate changes nothing and adds no stall
// - register copy writes its source unchanged, subject to the guard
// - copy is an add with zero register first, which reads zero
// - equality compare writes one when operands equal, else zero
//
// Purpose: execute stage for guarded byte select, clip, copy, add, compare, cache invalidate
// Assumes: operands already read from the register file; one operation per cycle
// Notes: results appear one cycle after issue; cache control strobes also one cycle after
`timescale 1ns/1ps
`include "byte_clip_consts.svh"
module guarded_ops_unit #(
  parameter int DestWidth = 6
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic issueValid,
  input wire logic [`OP_WIDTH-1:0] opCode,
  input wire logic [31:0] firstSourceOperand,
  input wire logic [31:0] secondSourceOperand,
  input wire logic guardPresent,
  input wire logic [31:0] guardValue,
  input wire logic [DestWidth-1:0] destIndex,
  output logic writeEnable,
  output logic [31:0] writeData,
  output logic [DestWidth-1:0] writeIndex,
  output logic cacheValidClear,
  output logic prefetchDiscard,
  output logic fetchSquash
);
  // elaboration check: the state struct holds a six-bit destination field
  if (DestWidth != 6)
  begin
    $error("destination index width must match the state struct (6)");
  end

  ////////////////////////////////////////////////////////////////////////
  byte_clip_pkg::unit_state_s state_q;
  byte_clip_pkg::unit_state_s state_d;
  logic [31:0] byteResult;
  logic guardTrue;
  logic signed [31:0] lowBound;
  logic signed [31:0] highBound;
  logic [31:0] addFirst;

  // issue decode shared by the checks below; values come in as arguments
  // so that the checks see sampled values, not the current ones
  function automatic logic takesOp(
    input logic valid,
    input logic guard,
    input logic [`OP_WIDTH-1:0] code,
    input logic [`OP_WIDTH-1:0] want
  );
    return valid && guard && (code == want);
  endfunction

  byte_select_unit #(
    .DataWidth(32)
  ) byteSel (
    .word(firstSourceOperand),
    .index(secondSourceOperand),
    .result(byteResult)
  );

  ////////////////////////////////////////////////////////////////////////
  // guard evaluation
  assign guardTrue = !guardPresent || guardValue[0];
  // clip bounds; relies on the bound being non-negative
  // bound kept in range by software, so negation cannot overflow
  assign highBound = $signed(secondSourceOperand);
  assign lowBound = -$signed(secondSourceOperand) - 32'sd1;
  // copy adds onto the zero register, which always reads zero
  assign addFirst = (opCode == `OP_COPY) ? `ZERO_WORD : firstSourceOperand;

  // next-state: at most one result per issued operation
  always_comb
  begin
    state_d = '0;
    state_d.destIdx = destIndex;
    state_d.shadowCount = (state_q.shadowCount != 2'h0) ? state_q.shadowCount - 2'h1 : 2'h0;
    if (issueValid && guardTrue)
    begin
      unique case (opCode)
        `OP_BYTESEL:
        begin
          state_d.result = byteResult;
          state_d.resultValid = 1'b1;
        end
        `OP_CLIP:
        begin
          if ($signed(firstSourceOperand) > highBound)
          begin
            state_d.result = highBound;
          end
          else if ($signed(firstSourceOperand) < lowBound)
          begin
            state_d.result = lowBound;
          end
          else
          begin
            state_d.result = firstSourceOperand;
          end
          state_d.resultValid = 1'b1;
        end
        `OP_COPY, `OP_ADD:
        begin
          state_d.result = addFirst + secondSourceOperand;
          state_d.resultValid = 1'b1;
        end
        `OP_EQUAL:
        begin
          state_d.result = {31'h0, firstSourceOperand == secondSourceOperand};
          state_d.resultValid = 1'b1;
        end
        `OP_INVAL:
        begin
          // clear valids, flush prefetch, squash two followers
          state_d.invalPulse = 1'b1;
          state_d.prefetchFlush = 1'b1;
          state_d.shadowCount = `INVAL_SHADOW;
        end
        default:
        begin
          state_d.resultValid = 1'b0;
        end
      endcase
    end
    // a guarded-off invalidate falls through with no pulse and no stall
    // squash level is kept in a flop so the output needs no decode after the register
    state_d.squashActive = (state_d.shadowCount != 2'h0);
  end

  // state register, synchronous active-low reset
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      state_q <= '0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs straight from the state register
  assign writeEnable = state_q.resultValid;
  assign writeData = state_q.result;
  assign writeIndex = state_q.destIdx;
  // valid-bit clear only; replacement bits are not on this port
  assign cacheValidClear = state_q.invalPulse;
  assign prefetchDiscard = state_q.prefetchFlush;
  // squash covers i+1 and i+2 only
  assign fetchSquash = state_q.squashActive;

  ////////////////////////////////////////////////////////////////////////
  AST_GUARD_BLOCKS: assert property (@(posedge clk) disable iff (!resetn)
    issueValid && guardPresent && !guardValue[0] |=> !writeEnable && !cacheValidClear)
    else $error("guarded-off operation took effect");
  AST_NO_GUARD_WRITES: assert property (@(posedge clk) disable iff (!resetn)
    issueValid && !guardPresent && opCode == `OP_COPY |=> writeEnable)
    else $error("unguarded copy did not write");
  AST_BYTESEL: assert property (@(posedge clk) disable iff (!resetn)
    issueValid && guardTrue && opCode == `OP_BYTESEL && secondSourceOperand == 32'h0000_0003
    |=> writeData == {{24{$past(firstSourceOperand[31])}}, $past(firstSourceOperand[31:24])})
    else $error("byte select result wrong");
  AST_CLIP_RANGE: assert property (@(posedge clk) disable iff (!resetn)
    issueValid && guardTrue && opCode == `OP_CLIP && !secondSourceOperand[31]
    |=> $signed(writeData) <= $signed($past(secondSourceOperand))
        && $signed(writeData) >= -$signed($past(secondSourceOperand)) - 32'sd1)
    else $error("clip result out of range");
  AST_COPY: assert property (@(posedge clk) disable iff (!resetn)
    issueValid && guardTrue && opCode == `OP_COPY |=> writeData == $past(secondSourceOperand))
    else $error("copy altered its source");
  AST_EQUAL: assert property (@(posedge clk) disable iff (!resetn)
    issueValid && guardTrue && opCode == `OP_EQUAL
    |=> writeData == {31'h0, $past(firstSourceOperand) == $past(secondSourceOperand)})
    else $error("compare result wrong");
  AST_INVAL: assert property (@(posedge clk) disable iff (!resetn)
    issueValid && guardTrue && opCode == `OP_INVAL |=> cacheValidClear && prefetchDiscard)
    else $error("invalidate did not clear and flush");
  AST_SQUASH: assert property (@(posedge clk) disable iff (!resetn)
    issueValid && guardTrue && opCode == `OP_INVAL ##1 !(issueValid && guardTrue && opCode == `OP_INVAL)
    ##1 !(issueValid && guardTrue && opCode == `OP_INVAL) |-> fetchSquash ##1 !fetchSquash)
    else $error("squash window is not two instructions");
  AST_NOSTALL: assert property (@(posedge clk) disable iff (!resetn)
    issueValid && !guardTrue && opCode == `OP_INVAL && !fetchSquash |=> !fetchSquash && !prefetchDiscard)
    else $error("false-guard invalidate stalled");
  // lane zero is the least significant byte
  AST_BYTESEL_LOW: assert property (@(posedge clk) disable iff (!resetn)
    takesOp(issueValid, guardTrue, opCode, `OP_BYTESEL) && secondSourceOperand == 32'h0000_0000
    |=> writeData == {{24{$past(firstSourceOperand[7])}}, $past(firstSourceOperand[7:0])})
    else $error("byte select lane zero wrong");
  // a value already inside the range must pass untouched
  AST_CLIP_PASS: assert property (@(posedge clk) disable iff (!resetn)
    takesOp(issueValid, guardTrue, opCode, `OP_CLIP) && !secondSourceOperand[31]
    && $signed(firstSourceOperand) <= $signed(secondSourceOperand)
    && $signed(firstSourceOperand) >= -$signed(secondSourceOperand) - 32'sd1
    |=> writeData == $past(firstSourceOperand))
    else $error("in-range clip operand was altered");
  AST_SQUASH_START: assert property (@(posedge clk) disable iff (!resetn)
    takesOp(issueValid, guardTrue, opCode, `OP_INVAL) |=> fetchSquash)
    else $error("squash did not start after invalidate");
  AST_COPY_DEST: assert property (@(posedge clk) disable iff (!resetn)
    takesOp(issueValid, guardTrue, opCode, `OP_COPY) |=> writeEnable && writeIndex == $past(destIndex))
    else $error("copy wrote the wrong destination");
  // invalidate has no destination, so it must not disturb the write port
  AST_INVAL_NO_WRITE: assert property (@(posedge clk) disable iff (!resetn)
    takesOp(issueValid, guardTrue, opCode, `OP_INVAL) |=> !writeEnable)
    else $error("invalidate wrote a register");
endmodule

// ===== byte_clip_consts.svh
// Purpose: shared constants for the guarded byte-select, clip, copy, compare and cache-invalidate unit
// Assumes: 32-bit data path, one clock
// Notes: op codes here are this unit's own encoding
`ifndef BYTE_CLIP_CONSTS_SVH
`define BYTE_CLIP_CONSTS_SVH
`define DATA_WIDTH 32
`define OP_WIDTH 3
`define OP_NOP 3'h0
`define OP_BYTESEL 3'h1
`define OP_CLIP 3'h2
`define OP_COPY 3'h3
`define OP_EQUAL 3'h4
`define OP_ADD 3'h5
`define OP_INVAL 3'h6
`define INVAL_SHADOW 2'h2
`define ZERO_WORD 32'h0000_0000
`endif

// ===== byte_clip_pkg.sv
// Purpose: types for the guarded operation unit
// Assumes: constants come from byte_clip_consts.svh
// Notes: the state struct is the whole state of the top module
package byte_clip_pkg;
  typedef struct packed {
    logic resultValid;
    logic [31:0] result;
    logic [5:0] destIdx;
    logic invalPulse;
    logic prefetchFlush;
    logic [1:0] shadowCount;
    logic squashActive;
  } unit_state_s;
endpackage

// ===== byte_select_unit.sv
// Purpose: combinational byte select with sign extension
// Assumes: index arrives as a full 32-bit operand
// Notes: only the low two index bits steer the mux
`timescale 1ns/1ps
module byte_select_unit #(
  parameter int DataWidth = 32
) (
  input wire logic [DataWidth-1:0] word,
  input wire logic [DataWidth-1:0] index,
  output logic [DataWidth-1:0] result
);
  // elaboration check: the lane mux and the sign fill assume four byte lanes
  if (DataWidth != 32)
  begin
    $error("byte_select_unit serves only 32-bit words");
  end
  logic [7:0] picked;
  // lane pick; indices above three give an undefined-by-contract value (low bits used)
  always_comb
  begin
    picked = word[8*index[1:0] +: 8];
    result = {{(DataWidth-8){picked[7]}}, picked};
  end
endmodule

// ===== reg_file_model.sv
// Purpose: register file behind the guarded operation unit
// Assumes: one write port, one read port
// Notes: reads are combinational
`timescale 1ns/1ps
module reg_file_model (
  input wire logic clk,
  input wire logic writeEnable,
  input wire logic [5:0] writeIndex,
  input wire logic [31:0] writeData,
  input wire logic [5:0] readIndex,
  output logic [31:0] readData
);
  logic [31:0] regs_q [64];
  assign readData = (readIndex == 6'h00) ? 32'h0000_0000 : regs_q[readIndex];
  // unwritten registers stay unknown so a lost write shows
  always_ff @(posedge clk)
  begin
    if (writeEnable)
    begin
      regs_q[writeIndex] <= writeData;
    end
  end
endmodule

// ===== tb.sv
// Purpose: self-checking bench for the guarded operation unit
// Assumes: results one cycle after issue, inputs driven on falling edge
// Notes: register file model captures the write port
`timescale 1ns/1ps
`include "byte_clip_consts.svh"
module tb;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic issueValid = 1'b0;
  logic [2:0] opCode = `OP_NOP;
  logic [31:0] opA = '0;
  logic [31:0] opB = '0;
  logic guardPresent = 1'b0;
  logic [31:0] guardValue = '0;
  logic [5:0] destIndex = '0;
  logic [5:0] readIndex = '0;
  logic writeEnable, cacheValidClear, prefetchDiscard, fetchSquash;
  logic [31:0] writeData, readData;
  logic [5:0] writeIndex;
  int failCount = 0;
  int nChecks = 0;
  always #2 clk = ~clk;
  guarded_ops_unit i_guarded_ops_unit (.clk(clk), .resetn(resetn), .issueValid(issueValid),
    .opCode(opCode), .firstSourceOperand(opA), .secondSourceOperand(opB),
    .guardPresent(guardPresent), .guardValue(guardValue), .destIndex(destIndex),
    .writeEnable(writeEnable), .writeData(writeData), .writeIndex(writeIndex),
    .cacheValidClear(cacheValidClear), .prefetchDiscard(prefetchDiscard), .fetchSquash(fetchSquash));
  reg_file_model i_reg_file_model (.clk(clk), .writeEnable(writeEnable), .writeIndex(writeIndex),
    .writeData(writeData), .readIndex(readIndex), .readData(readData));
  ////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    nChecks++;
    if (s !== e)
    begin
      $display("unexpected %s: expected %h seen %h", nm, e, s);
      failCount++;
    end
  endtask
  // issue stays up so back-to-back ops never toggle valid twice
  task issue(input logic [2:0] op, input logic [31:0] a, b, input logic gp, gv, input logic [5:0] d);
    opCode = op;
    opA = a;
    opB = b;
    guardPresent = gp;
    guardValue = gv ? 32'h0000_0001 : 32'hffff_fffe; // upper bits set when false, only bit zero counts
    destIndex = d;
    issueValid = 1'b1;
    @(negedge clk);
  endtask
  task idle;
    issueValid = 1'b0;
    @(negedge clk);
  endtask
  ////////////////////////////////////////////////////////////////
  task t_bytesel;
    logic [31:0] w;
    w = 32'hddcc_7faa;
    for (int k = 0; k < 4; k++)
    begin
      issue(`OP_BYTESEL, w, k, 1'b0, 1'b0, 6'h05);
      chk("bytesel", writeData, {{24{w[8*k+7]}}, w[8*k+:8]});
      chk("wen", writeEnable, 1);
      chk("widx", writeIndex, 6'h05);
    end
    idle();
  endtask
  task t_clip;
    logic [31:0] ca [4] = '{32'h0000_0080, 32'h8000_0000, 32'hffff_fff0, 32'h1234_5678};
    logic [31:0] cb [4] = '{32'h0000_007f, 32'h003f_ffff, 32'h0000_0000, 32'h7fff_ffff};
    logic [31:0] ce [4] = '{32'h0000_007f, 32'hffc0_0000, 32'hffff_ffff, 32'h1234_5678};
    // bounds stay within zero to the largest positive value
    for (int k = 0; k < 4; k++)
    begin
      issue(`OP_CLIP, ca[k], cb[k], 1'b1, 1'b1, 6'h06);
      chk("clip", writeData, ce[k]);
    end
    idle();
  endtask
  task t_guard;
    // nonzero first operand: a copy that used it instead of the zero register would show
    issue(`OP_COPY, 32'h1234_5678, 32'h0000_0005, 1'b0, 1'b0, 6'h09);
    chk("copy", writeData, 32'h0000_0005);
    issue(`OP_COPY, 32'h0000_0000, 32'h0000_0007, 1'b1, 1'b0, 6'h09);
    chk("wen off", writeEnable, 0);
    issue(`OP_ADD, 32'h0000_0100, 32'h0000_0100, 1'b1, 1'b1, 6'h0a);
    chk("add", writeData, 32'h0000_0200);
    readIndex = 6'h09;
    idle();
    chk("kept", readData, 32'h0000_0005);
  endtask
  task t_equal;
    issue(`OP_EQUAL, 32'h8000_0000, 32'h8000_0000, 1'b0, 1'b0, 6'h0b);
    chk("eq", writeData, 1);
    issue(`OP_EQUAL, 32'h0000_0003, 32'h0000_0004, 1'b0, 1'b0, 6'h0b);
    chk("neq", writeData, 0);
    idle();
  endtask
  task t_inval;
    issue(`OP_INVAL, 0, 0, 1'b1, 1'b1, 6'h00);
    chk("clear", {cacheValidClear, prefetchDiscard, fetchSquash, writeEnable}, 4'he);
    idle();
    chk("c2", {cacheValidClear, prefetchDiscard, fetchSquash}, 3'h1);
    idle();
    chk("c3", fetchSquash, 0);
    issue(`OP_INVAL, 0, 0, 1'b1, 1'b0, 6'h00);
    chk("off", {cacheValidClear, prefetchDiscard, fetchSquash}, 3'h0);
    issue(`OP_INVAL, 0, 0, 1'b0, 1'b0, 6'h00);
    chk("bare", {cacheValidClear, prefetchDiscard, fetchSquash}, 3'h7);
    idle();
    idle();
  endtask
  ////////////////////////////////////////////////////////////////
  task stopTest;
    $display("checks %0d mismatches %0d", nChecks, failCount);
    if (failCount == 0 && nChecks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // reset for 20 cycles, then each scenario in turn
  initial
  begin
    repeat (20) @(negedge clk);
    chk("reset", {writeEnable, cacheValidClear, prefetchDiscard, fetchSquash}, 4'h0);
    resetn = 1'b1;
    t_bytesel();
    t_clip();
    t_guard();
    t_equal();
    t_inval();
    stopTest();
  end
endmodule
